// *** port_spi_command_master.sv ***
`timescale 1ns/10ps
`default_nettype none
module port_spi_command_master #(
  parameter int HALF_CYC = spi_cmd_pkg::SCK_HALF_CYC
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  input wire logic rsp_ready_i,
  input wire logic value_wr_i,
  input wire logic dir_wr_i,
  input wire spi_cmd_pkg::port_cfg_t cfg_i,
  output spi_cmd_pkg::port_cfg_t cfg_o,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  output logic [7:0] pin_level_o,
  output logic serial_mode_o,
  output logic busy_o
);
  import spi_cmd_pkg::*;

  if (HALF_CYC < 4 || HALF_CYC > 255)
  begin : g_bad_half
    $error("half clock period must be 4 to 255 cycles");
  end

  function automatic logic [7:0] serial_dir(input logic [7:0] dir);
    serial_dir = (dir & ~SERIAL_MASK) | SERIAL_OUT_MASK;
  endfunction

  state_t state_q, state_d;
  op_t op_q, op_d;
  port_cfg_t cfg_q, cfg_d, save_q, save_d;
  logic mode_q, mode_d;
  logic [7:0] count_q, count_d;
  logic [7:0] tx_q, tx_d, rx_q, rx_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] half_q, half_d;
  logic phase_q, phase_d;
  logic [1:0] idx_q, idx_d;
  logic [7:0] pin_q, pin_d, oe_q, oe_d;
  logic [7:0] pin_sync;
  logic miso, half_done, take, push_ok;
  logic en_act, dis_act;
  logic buf_valid, buf_ready;
  logic [7:0] buf_data;

  sync2 #(.WIDTH(8)) u_sync (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .async_i(pin_i),
    .sync_o(pin_sync)
  );

  // data-in line, sampled only through the synchroniser
  assign miso = pin_sync[MISO_BIT];

  byte_fifo2 #(.WIDTH(8), .DEPTH(2)) u_rsp_buf (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .in_valid_i(buf_valid),
    .in_data_i(buf_data),
    .in_ready_o(buf_ready),
    .out_valid_o(rsp_valid_o),
    .out_data_o(rsp_data_o),
    .out_ready_i(rsp_ready_i)
  );

  assign cmd_ready_o = (state_q == ST_IDLE) || (state_q == ST_CMD1) ||
                       (state_q == ST_CMD2) || (state_q == ST_LOAD);
  assign take = cmd_valid_i && cmd_ready_o;
  assign half_done = (half_q == 8'(HALF_CYC - 1));
  assign push_ok = buf_valid && buf_ready;
  assign en_act = take && (state_q == ST_CMD2) && (op_q == OP_ON) &&
                  (cmd_data_i == CH_A);
  assign dis_act = take && (state_q == ST_CMD2) && (op_q == OP_OFF) &&
                   (cmd_data_i == CH_A);

  // reply byte source
  always_comb
  begin
    buf_valid = 1'b0;
    buf_data = 8'h00;
    case (state_q)
      ST_ECHO:
      begin
        buf_valid = 1'b1;
        case (idx_q)
          2'h0: buf_data = CH_S;
          2'h1: buf_data = (op_q == OP_ON) ? CH_ON : CH_OFF;
          default: buf_data = CH_A;
        endcase
      end
      ST_HDR:
      begin
        buf_valid = 1'b1;
        case (idx_q)
          2'h0: buf_data = CH_S;
          2'h1: buf_data = CH_A;
          default: buf_data = count_q;
        endcase
      end
      ST_PUSH:
      begin
        buf_valid = 1'b1;
        buf_data = rx_q;
      end
      default:
      begin
        buf_valid = 1'b0;
        buf_data = 8'h00;
      end
    endcase
  end

  // command parser and shift engine
  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    count_d = count_q;
    tx_d = tx_q;
    rx_d = rx_q;
    bit_d = bit_q;
    half_d = half_q;
    phase_d = phase_q;
    idx_d = idx_q;
    case (state_q)
      ST_IDLE:
      begin
        if (take && cmd_data_i == CH_S)
        begin
          state_d = ST_CMD1;
        end
      end
      ST_CMD1:
      begin
        if (take)
        begin
          state_d = ST_CMD2;
          if (cmd_data_i == CH_ON)
          begin
            op_d = OP_ON;
          end
          else if (cmd_data_i == CH_OFF)
          begin
            op_d = OP_OFF;
          end
          else if (cmd_data_i == CH_A)
          begin
            op_d = OP_XFER;
          end
          else
          begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_CMD2:
      begin
        if (take)
        begin
          idx_d = 2'h0;
          if (op_q == OP_XFER)
          begin
            count_d = cmd_data_i;
            state_d = ST_HDR;
          end
          else if (cmd_data_i == CH_A)
          begin
            state_d = ST_ECHO;
          end
          else
          begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_ECHO:
      begin
        if (push_ok)
        begin
          idx_d = idx_q + 2'h1;
          if (idx_q == LAST_IDX)
          begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_HDR:
      begin
        if (push_ok)
        begin
          idx_d = idx_q + 2'h1;
          if (idx_q == LAST_IDX)
          begin
            state_d = (count_q == 8'h00) ? ST_IDLE : ST_LOAD;
          end
        end
      end
      ST_LOAD:
      begin
        if (take)
        begin
          tx_d = cmd_data_i;
          bit_d = 3'h0;
          half_d = 8'h00;
          phase_d = 1'b0;
          state_d = ST_SHIFT;
        end
      end
      ST_SHIFT:
      begin
        if (half_done)
        begin
          half_d = 8'h00;
          phase_d = ~phase_q;
          if (phase_q)
          begin
            rx_d = {rx_q[6:0], miso};
            tx_d = {tx_q[6:0], 1'b0};
            bit_d = bit_q + 3'h1;
            if (bit_q == LAST_BIT)
            begin
              state_d = ST_PUSH;
            end
          end
        end
        else
        begin
          half_d = half_q + 8'h01;
        end
      end
      ST_PUSH:
      begin
        if (push_ok)
        begin
          count_d = count_q - 8'h01;
          state_d = (count_q == 8'h01) ? ST_IDLE : ST_LOAD;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // port configuration, save and restore
  always_comb
  begin
    cfg_d = cfg_q;
    save_d = save_q;
    mode_d = mode_q;
    if (value_wr_i)
    begin
      cfg_d.value = cfg_i.value;
    end
    if (dir_wr_i)
    begin
      cfg_d.dir = cfg_i.dir;
    end
    if (en_act && !mode_q)
    begin
      save_d = cfg_q;
      cfg_d.dir = serial_dir(cfg_q.dir);
      mode_d = 1'b1;
    end
    else if (dis_act && mode_q)
    begin
      cfg_d = save_q;
      mode_d = 1'b0;
    end
  end

  // pin drive
  always_comb
  begin
    pin_d = cfg_q.value;
    oe_d = cfg_q.dir;
    if (mode_q)
    begin
      oe_d = serial_dir(cfg_q.dir);
      pin_d[SCK_BIT] = cfg_q.value[SCK_BIT] ^ phase_q;
      pin_d[MOSI_BIT] = tx_q[7];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_q <= ST_IDLE;
      op_q <= OP_ON;
      count_q <= 8'h00;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      bit_q <= 3'h0;
      half_q <= 8'h00;
      phase_q <= 1'b0;
      idx_q <= 2'h0;
      cfg_q <= '{value: PORT_VALUE_RST, dir: PORT_DIR_RST};
      save_q <= '{value: PORT_VALUE_RST, dir: PORT_DIR_RST};
      mode_q <= 1'b0;
      pin_q <= PORT_VALUE_RST;
      oe_q <= PORT_DIR_RST;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      count_q <= count_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      bit_q <= bit_d;
      half_q <= half_d;
      phase_q <= phase_d;
      idx_q <= idx_d;
      cfg_q <= cfg_d;
      save_q <= save_d;
      mode_q <= mode_d;
      pin_q <= pin_d;
      oe_q <= oe_d;
    end
  end

  assign pin_o = pin_q;
  assign pin_oe_o = oe_q;
  assign pin_level_o = pin_sync;
  assign cfg_o = cfg_q;
  assign serial_mode_o = mode_q;
  assign busy_o = (state_q != ST_IDLE);

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  a_enable_sets_dir: assert property (
    (en_act && !mode_q) |=> mode_q && cfg_q.dir[SCK_BIT] && cfg_q.dir[MOSI_BIT]
      && !cfg_q.dir[MISO_BIT] ##3 (state_q == ST_ECHO || state_q == ST_IDLE))
    else $error("enable did not set serial directions");

  a_enable_saves: assert property (
    (en_act && !mode_q) |=> save_q == $past(cfg_q))
    else $error("port state not saved on enable");

  a_disable_restores: assert property (
    (dis_act && mode_q && !value_wr_i && !dir_wr_i) |=>
      !mode_q && cfg_q == $past(save_q))
    else $error("port state not restored on disable");

  a_capture_bit: assert property (
    (state_q == ST_SHIFT && half_done && phase_q) |=> rx_q[0] == $past(miso))
    else $error("data-in bit not captured");

  a_count_down: assert property (
    (state_q == ST_PUSH && push_ok) |=> count_q == $past(count_q) - 8'h01)
    else $error("reply byte count mismatch");

  a_clock_dir: assert property (
    $past(mode_q) |-> pin_oe_o[SCK_BIT] && pin_oe_o[MOSI_BIT] && !pin_oe_o[MISO_BIT])
    else $error("serial line directions wrong");

  a_data_out: assert property (
    $past(mode_q) |-> pin_o[MOSI_BIT] == $past(tx_q[7]))
    else $error("data-out line not driven from shifter");

  a_other_lines: assert property (
    $past(mode_q) |-> (pin_o & ~SERIAL_MASK) == ($past(cfg_q.value) & ~SERIAL_MASK))
    else $error("general lines disturbed in serial mode");

  a_sck_idle: assert property (
    ($past(mode_q) && $past(state_q) != ST_SHIFT) |->
      pin_o[SCK_BIT] == $past(cfg_q.value[SCK_BIT]))
    else $error("clock idle level wrong");

  a_eight_bits: assert property (
    (state_q == ST_SHIFT && state_d == ST_PUSH) |-> bit_q == LAST_BIT && phase_q)
    else $error("byte ended before eight clocks");

  a_zero_count: assert property (
    (state_q == ST_HDR && count_q == 8'h00) |-> state_d != ST_LOAD ##1
      (state_q != ST_SHIFT)[*3])
    else $error("clock activity on empty transfer");
endmodule
`default_nettype wire

// *** spi_cmd_pkg.sv ***
package spi_cmd_pkg;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_ON = 8'h31;
  localparam logic [7:0] CH_OFF = 8'h30;
  localparam int SCK_BIT = 0;
  localparam int MOSI_BIT = 1;
  localparam int MISO_BIT = 2;
  localparam logic [7:0] SERIAL_OUT_MASK = 8'h03;
  localparam logic [7:0] SERIAL_MASK = 8'h07;
  localparam logic [7:0] PORT_VALUE_RST = 8'h00;
  localparam logic [7:0] PORT_DIR_RST = 8'h00;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCK_HALF_NS = 80;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] LAST_IDX = 2'h2;
  typedef struct packed
  {
    logic [7:0] value;
    logic [7:0] dir;
  } port_cfg_t;
  typedef enum logic [1:0]
  {
    OP_ON = 2'b00,
    OP_OFF = 2'b01,
    OP_XFER = 2'b10
  } op_t;
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'b0000,
    ST_CMD1 = 4'b0001,
    ST_CMD2 = 4'b0010,
    ST_ECHO = 4'b0011,
    ST_HDR = 4'b0100,
    ST_LOAD = 4'b0101,
    ST_SHIFT = 4'b0110,
    ST_PUSH = 4'b0111
  } state_t;
endpackage

// *** sync2.sv ***
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 8
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule
`default_nettype wire

// *** byte_fifo2.sv ***
`timescale 1ns/10ps
`default_nettype none
module byte_fifo2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("depth must be a power of two of at least two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb
  begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// *** spi_slave_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic cs_n_i,
  input wire logic idle_i,
  output logic miso_o,
  output logic [7:0] rx_o,
  output logic [15:0] pulses_o
);
  logic [7:0] tx_q;
  logic [7:0] sh_q;
  logic [3:0] bits_q;
  logic last_q;
  initial
  begin
    tx_q = 8'hc3;
    sh_q = 8'h00;
    bits_q = 4'h0;
    last_q = 1'b0;
    rx_o = 8'h00;
    pulses_o = 16'h0000;
  end
  // frame start reloads the first reply byte
  always @(negedge cs_n_i)
  begin
    tx_q = 8'hc3;
    bits_q = 4'h0;
  end
  always @(posedge cs_n_i)
    last_q = tx_q[7];
  // leading edge samples data out, trailing edge moves data in
  always @(sck_i)
  begin
    if (cs_n_i === 1'b0 && sck_i !== idle_i)
    begin
      sh_q = {sh_q[6:0], mosi_i};
      pulses_o = pulses_o + 16'h0001;
    end
    else if (cs_n_i === 1'b0)
    begin
      bits_q = bits_q + 4'h1;
      tx_q = (bits_q == 4'h8) ? sh_q : {tx_q[6:0], 1'b0};
      if (bits_q == 4'h8)
      begin
        rx_o = sh_q;
        bits_q = 4'h0;
      end
    end
  end
  // deselected line shows the inverse of its last bit
  assign miso_o = cs_n_i ? ~last_q : tx_q[7];
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  import spi_cmd_pkg::*;
  logic clock_i, rstn_i, cmd_valid_i, rsp_ready_i, value_wr_i, dir_wr_i, idle_q, miso;
  logic cmd_ready_o, rsp_valid_o, serial_mode_o, busy_o;
  logic [7:0] cmd_data_i, rsp_data_o, pin_i, pin_o, pin_oe_o, pin_level_o, ext_q, base_q, rx_last;
  logic [7:0] none_q[$];
  logic [15:0] pulses;
  port_cfg_t cfg_i, cfg_o;
  int fail_count = 0;
  int checks_done = 0;
  port_spi_command_master #(.HALF_CYC(4)) port_spi_command_master_i (.clock_i(clock_i),
    .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i), .cmd_data_i(cmd_data_i),
    .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .rsp_ready_i(rsp_ready_i), .value_wr_i(value_wr_i), .dir_wr_i(dir_wr_i), .cfg_i(cfg_i),
    .cfg_o(cfg_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pin_level_o(pin_level_o), .serial_mode_o(serial_mode_o), .busy_o(busy_o));
  spi_slave_model spi_slave_model_i (.sck_i(pin_o[SCK_BIT]), .mosi_i(pin_o[MOSI_BIT]),
    .cs_n_i(pin_o[3]), .idle_i(idle_q), .miso_o(miso), .rx_o(rx_last), .pulses_o(pulses));
  // wire level: driven pins loop back, others from outside
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & (miso ? (ext_q | 8'h04) : (ext_q & 8'hfb)));
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic test_end(input string name);
    $display("test %s ended, mismatches %0d", name, fail_count);
  endtask
  task automatic put(input logic [7:0] b);
    logic r;
    int n;
    cmd_valid_i <= 1'b1;
    cmd_data_i <= b;
    n = 0;
    do
    begin
      @(negedge clock_i);
      r = cmd_ready_o;
      @(posedge clock_i);
      n++;
    end while (r !== 1'b1 && n < 3000);
    if (r !== 1'b1) `CHK(r, 1'b1)
  endtask
  task automatic get(input logic [7:0] e);
    logic v;
    logic [7:0] d;
    int n;
    rsp_ready_i <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clock_i);
      v = rsp_valid_o;
      d = rsp_data_o;
      @(posedge clock_i);
      n++;
    end while (v !== 1'b1 && n < 3000);
    `CHK({v, d}, {1'b1, e})
  endtask
  // replies are drained late so the engine stalls on a full buffer
  task automatic run(input logic [7:0] tx[$], input logic [7:0] rx[$]);
    fork
      begin
        foreach (tx[i]) put(tx[i]);
        cmd_valid_i <= 1'b0;
      end
      begin
        repeat (40) @(posedge clock_i);
        foreach (rx[i]) get(rx[i]);
        rsp_ready_i <= 1'b0;
      end
    join
    repeat (4) @(posedge clock_i);
    `CHK(rsp_valid_o, 1'b0)
    `CHK(busy_o, 1'b0)
  endtask
  task automatic wr_cfg(input logic [7:0] v, input logic [7:0] d, input logic wd);
    cfg_i <= {v, d};
    value_wr_i <= 1'b1;
    dir_wr_i <= wd;
    @(posedge clock_i);
    value_wr_i <= 1'b0;
    dir_wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  // select low, prefix, count, payload; reply echoes slave bytes
  task automatic xfer(input logic [7:0] d[$]);
    logic [7:0] tx[$];
    logic [7:0] rx[$];
    logic [15:0] p0;
    tx = {CH_S, CH_A, 8'(d.size())};
    rx = tx;
    foreach (d[i])
    begin
      tx.push_back(d[i]);
      rx.push_back(i == 0 ? 8'hc3 : d[i - 1]);
    end
    wr_cfg(base_q & 8'hf7, 8'h18, 1'b0);
    p0 = pulses;
    run(tx, rx);
    `CHK(pulses - p0, 16'(8 * d.size()))
    `CHK(pin_o[SCK_BIT], idle_q)
    if (d.size() > 0) `CHK(rx_last, d[d.size() - 1])
    wr_cfg(base_q, 8'h18, 1'b0);
  endtask
  initial
  begin
    #200000;
    fail_count++;
    final_report;
  end
  initial
  begin
    rstn_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_data_i = 8'h00;
    rsp_ready_i = 1'b0;
    value_wr_i = 1'b0;
    dir_wr_i = 1'b0;
    cfg_i = 16'h0000;
    ext_q = 8'h20;
    idle_q = 1'b1;
    base_q = 8'h19;
    repeat (3) @(posedge clock_i);
    `CHK({cmd_ready_o, rsp_valid_o, serial_mode_o, busy_o}, 4'b1000)
    `CHK(pin_oe_o, 8'h00)
    `CHK(cfg_o, 16'h0000)
    rstn_i <= 1'b1;
    @(posedge clock_i);
    test_end("reset");
    wr_cfg(8'h19, 8'h18, 1'b1);
    `CHK(pin_level_o[5], 1'b1)
    run({CH_S, CH_ON, CH_A}, {CH_S, CH_ON, CH_A});
    `CHK(serial_mode_o, 1'b1)
    `CHK(pin_oe_o, 8'h1b)
    `CHK(pin_o[SCK_BIT], 1'b1)
    `CHK(pin_level_o[5], 1'b1)
    test_end("enable");
    xfer({8'haa, 8'h55});
    xfer({8'hff, 8'haa, 8'h55});
    test_end("transfer idle high");
    run({8'h58, CH_S, 8'h58, CH_S, CH_OFF, 8'h58, CH_S, CH_OFF, CH_A}, {CH_S, CH_OFF, CH_A});
    `CHK(serial_mode_o, 1'b0)
    `CHK(cfg_o, {8'h19, 8'h18})
    `CHK(pin_oe_o, 8'h18)
    test_end("disable");
    base_q = 8'h18;
    idle_q = 1'b0;
    wr_cfg(8'h18, 8'h18, 1'b1);
    run({CH_S, CH_ON, CH_A}, {CH_S, CH_ON, CH_A});
    `CHK(pin_o[SCK_BIT], 1'b0)
    xfer({8'h01, 8'h80, 8'h00});
    xfer(none_q);
    run({CH_S, CH_OFF, CH_A}, {CH_S, CH_OFF, CH_A});
    `CHK(cfg_o, {8'h18, 8'h18})
    test_end("idle low");
    final_report;
  end
endmodule
`default_nettype wire
